// *** logic/fwg_pkg.sv ***
// Shared constants, state encodings and request carriers of the flash write and erase guard.
package fwg_pkg;

  // Address width of the core's external data space and of the debug port.
  localparam int XADDR_W = 16;
  // One page holds 512 bytes.
  localparam int PAGE_OFS_W = 9;

  // Key codes and the value of an erased byte.
  localparam logic [7:0] KEY_FIRST   = 8'hA5;
  localparam logic [7:0] KEY_SECOND  = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Register offsets on the plain register port.
  localparam int         REG_ADDR_W = 4;
  localparam logic [3:0] OFS_PSC    = 4'h0;
  localparam logic [3:0] OFS_KEY    = 4'h1;
  localparam logic [3:0] OFS_RSRC   = 4'h2;
  localparam logic [3:0] OFS_STAT   = 4'h3;
  localparam logic [3:0] OFS_LOCK   = 4'h4;

  // Field positions.
  localparam int PSC_WE_BIT    = 0;
  localparam int PSC_EE_BIT    = 1;
  localparam int RSRC_FERR_BIT = 6;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OPEN_BIT = 1;
  localparam int STAT_DEAD_BIT = 2;
  localparam int STAT_ANYL_BIT = 3;

  // Reset values.
  localparam logic [1:0] PSC_RST      = 2'h0;
  localparam logic [7:0] LOCK_VAL_RST = 8'h00;

  // Operation times and the clock period, in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS  = 40000;
  localparam int ERASE_TIME_NS = 20000000;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OPEN = 2'h3,
    KEY_DEAD = 2'h2
  } fwg_key_e;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'h0,
    OP_PROG  = 2'h1,
    OP_ERASE = 2'h3,
    OP_DONE  = 2'h2
  } fwg_op_e;

  // Firmware access from the core: pc is the address being executed.
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [XADDR_W-1:0] addr;
    logic [7:0]         wdata;
    logic [XADDR_W-1:0] pc;
  } fwg_fw_req_s;

  // Debug port command, at most one strobe high at a time.
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic               page_erase;
    logic               dev_erase;
    logic [XADDR_W-1:0] addr;
    logic [7:0]         wdata;
  } fwg_dbg_req_s;

endpackage

// *** logic/fwg_flash_guard.sv ***
// Flash program and erase sequencer with key lock and page security.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fwg_flash_guard #(
  parameter int NUM_PAGES = 32,
  parameter int PROG_CYC  = (fwg_pkg::PROG_TIME_NS + fwg_pkg::CLK_PERIOD_NS - 1)
                            / fwg_pkg::CLK_PERIOD_NS,
  parameter int ERASE_CYC = (fwg_pkg::ERASE_TIME_NS + fwg_pkg::CLK_PERIOD_NS - 1)
                            / fwg_pkg::CLK_PERIOD_NS
) (
  // Clock, resets and clock enable
  input  wire logic                            i_mclk,
  input  wire logic                            i_rst,
  input  wire logic                            i_por,
  input  wire logic                            i_ce,
  // Register port
  input  wire logic [fwg_pkg::REG_ADDR_W-1:0]  i_reg_addr,
  input  wire logic [7:0]                      i_reg_wdata,
  input  wire logic                            i_reg_wr,
  input  wire logic                            i_reg_rd,
  output logic      [7:0]                      o_reg_rdata,
  // Core side
  input  wire fwg_pkg::fwg_fw_req_s            i_fw,
  output logic      [7:0]                      o_fw_rdata,
  output logic                                 o_xdm_to_flash,
  output logic                                 o_core_stall,
  // Supply monitor status
  input  wire logic                            i_supmon_en,
  input  wire logic                            i_supmon_rst_en,
  // Debug port side
  input  wire fwg_pkg::fwg_dbg_req_s           i_dbg,
  output logic      [7:0]                      o_dbg_rdata,
  output logic                                 o_dbg_rvalid,
  output logic                                 o_dbg_refused,
  // Device reset request
  output logic                                 o_flash_error_device_reset
);

  localparam int MA_W      = $clog2(NUM_PAGES) + fwg_pkg::PAGE_OFS_W;
  localparam int PG_W      = MA_W - fwg_pkg::PAGE_OFS_W;
  localparam int MEM_BYTES = NUM_PAGES << fwg_pkg::PAGE_OFS_W;
  localparam logic [PG_W-1:0] RSV_PAGE  = PG_W'(NUM_PAGES - 1);
  localparam logic [PG_W-1:0] LOCK_PAGE = PG_W'(NUM_PAGES - 2);
  localparam logic [MA_W-1:0] LOCK_ADDR = {LOCK_PAGE, {fwg_pkg::PAGE_OFS_W{1'b1}}};
  localparam logic [MA_W-1:0] PAGE_MASK = MA_W'((1 << fwg_pkg::PAGE_OFS_W) - 1);

  // Flash array; the top page is the reserved area, the one below holds the lock byte.
  logic [7:0] flash_mem [MEM_BYTES] = '{default: fwg_pkg::ERASED_BYTE};

  logic [1:0]          psc_reg;
  fwg_pkg::fwg_key_e   key_reg;
  fwg_pkg::fwg_op_e    op_reg;
  logic [31:0]         tmr_reg;
  logic [MA_W-1:0]     sweep_reg;
  logic [MA_W-1:0]     sweep_end_reg;
  logic                sweep_act_reg;
  logic                dev_erase_reg;
  logic [MA_W-1:0]     prog_addr_reg;
  logic [7:0]          prog_data_reg;
  logic [7:0]          lock_val_reg;
  logic                post_rst_reg;
  logic                ferr_cause_reg;
  logic                rsrc_ferr_reg;

  function automatic logic [PG_W-1:0] page_of(input logic [fwg_pkg::XADDR_W-1:0] a);
    return a[MA_W-1:fwg_pkg::PAGE_OFS_W];
  endfunction

  // Lock value holds the ones complement of the number of pages locked from page zero.
  function automatic logic page_locked(input logic [PG_W-1:0] p, input logic [7:0] lv);
    logic [7:0] cnt;
    cnt = ~lv;
    return (16'(p) < 16'(cnt)) || ((lv != fwg_pkg::ERASED_BYTE) && (p == LOCK_PAGE));
  endfunction

  function automatic logic is_reserved(input logic [fwg_pkg::XADDR_W-1:0] a);
    return (32'(a) >= MEM_BYTES) || (page_of(a) == RSV_PAGE);
  endfunction

  logic       busy;
  logic       any_locked;
  logic [7:0] lock_stored;
  logic       fw_pc_locked;
  logic       fw_tgt_locked;
  logic       fw_lock_byte;
  logic       fw_wr_att;
  logic       fw_viol;
  logic       fw_supply_bad;
  logic       flash_error_device_reset_req;
  logic       fw_start;
  logic       fw_blocked;
  logic       dbg_tgt_locked;
  logic       dbg_any;
  logic       dbg_ok;
  logic       key_wr;
  logic       tmr_zero;

  assign busy         = (op_reg != fwg_pkg::OP_IDLE);
  assign any_locked   = (lock_val_reg != fwg_pkg::ERASED_BYTE);
  assign lock_stored  = flash_mem[LOCK_ADDR];
  assign tmr_zero     = (tmr_reg == 32'h0);
  assign key_wr       = i_ce && i_reg_wr && (i_reg_addr == fwg_pkg::OFS_KEY);

  assign fw_pc_locked  = page_locked(page_of(i_fw.pc), lock_val_reg);
  assign fw_tgt_locked = page_locked(page_of(i_fw.addr), lock_val_reg);
  assign fw_lock_byte  = (i_fw.addr[MA_W-1:0] == LOCK_ADDR) && !is_reserved(i_fw.addr);
  assign fw_wr_att     = i_ce && !busy && !post_rst_reg && i_fw.wr
                         && psc_reg[fwg_pkg::PSC_WE_BIT];
  assign fw_supply_bad = !(i_supmon_en && i_supmon_rst_en);

  // Any firmware violation ends in a device reset rather than a silent refusal.
  always_comb begin
    fw_viol = 1'b0;
    if (is_reserved(i_fw.addr)) begin
      fw_viol = 1'b1;
    end
    if (fw_tgt_locked && !fw_pc_locked) begin
      fw_viol = 1'b1;
    end
    if (i_fw.wr && psc_reg[fwg_pkg::PSC_EE_BIT] && (page_of(i_fw.addr) == LOCK_PAGE)) begin
      fw_viol = 1'b1;
    end
    if (i_fw.wr && !psc_reg[fwg_pkg::PSC_EE_BIT] && fw_lock_byte
        && (lock_stored != fwg_pkg::ERASED_BYTE)) begin
      fw_viol = 1'b1;
    end
  end

  assign flash_error_device_reset_req = (fw_wr_att && (fw_supply_bad || fw_viol))
                    || (i_ce && !busy && !post_rst_reg && i_fw.rd && fw_viol);
  assign fw_blocked = (key_reg != fwg_pkg::KEY_OPEN);
  assign fw_start   = fw_wr_att && !flash_error_device_reset_req && !fw_blocked;

  // The debug port acts with no executing page, so every locked page is closed to its reads, writes and page erases.
  assign dbg_tgt_locked = page_locked(page_of(i_dbg.addr), lock_val_reg);
  assign dbg_any = i_ce && !post_rst_reg
                   && (i_dbg.rd || i_dbg.wr || i_dbg.page_erase || i_dbg.dev_erase);

  always_comb begin
    dbg_ok = 1'b0;
    if (busy || fw_start) begin
      dbg_ok = 1'b0;
    end else if (i_dbg.dev_erase) begin
      dbg_ok = 1'b1;
    end else if (is_reserved(i_dbg.addr) || dbg_tgt_locked) begin
      dbg_ok = 1'b0;
    end else if (i_dbg.wr) begin
      dbg_ok = !((i_dbg.addr[MA_W-1:0] == LOCK_ADDR)
                 && (lock_stored != fwg_pkg::ERASED_BYTE));
    end else begin
      dbg_ok = 1'b1;
    end
  end

  // Program store control.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      psc_reg <= fwg_pkg::PSC_RST;
    end else if (i_ce && i_reg_wr && (i_reg_addr == fwg_pkg::OFS_PSC)) begin
      psc_reg <= i_reg_wdata[1:0];
    end
  end

  assign o_xdm_to_flash = psc_reg[fwg_pkg::PSC_WE_BIT];

  // Key lock: a dead lock survives everything but a system reset.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      key_reg <= fwg_pkg::KEY_IDLE;
    end else if (i_ce) begin
      if (key_reg == fwg_pkg::KEY_DEAD) begin
        key_reg <= fwg_pkg::KEY_DEAD;
      end else if (fw_wr_att && !flash_error_device_reset_req && fw_blocked) begin
        key_reg <= fwg_pkg::KEY_DEAD;
      end else if (fw_start) begin
        key_reg <= fwg_pkg::KEY_IDLE;
      end else if (key_wr) begin
        case (key_reg)
          fwg_pkg::KEY_IDLE: begin
            key_reg <= (i_reg_wdata == fwg_pkg::KEY_FIRST) ? fwg_pkg::KEY_HALF
                                                           : fwg_pkg::KEY_DEAD;
          end
          fwg_pkg::KEY_HALF: begin
            key_reg <= (i_reg_wdata == fwg_pkg::KEY_SECOND) ? fwg_pkg::KEY_OPEN
                                                            : fwg_pkg::KEY_DEAD;
          end
          default: begin
            key_reg <= fwg_pkg::KEY_DEAD;
          end
        endcase
      end
    end
  end

  // Operation sequencer; a program ends on the timer, an erase on the timer and the end of the sweep.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      op_reg        <= fwg_pkg::OP_IDLE;
      tmr_reg       <= 32'h0;
      dev_erase_reg <= 1'b0;
      prog_addr_reg <= '0;
      prog_data_reg <= 8'h00;
    end else if (i_ce) begin
      case (op_reg)
        fwg_pkg::OP_IDLE: begin
          if (fw_start && !psc_reg[fwg_pkg::PSC_EE_BIT]) begin
            op_reg        <= fwg_pkg::OP_PROG;
            tmr_reg       <= 32'(PROG_CYC - 1);
            prog_addr_reg <= i_fw.addr[MA_W-1:0];
            prog_data_reg <= i_fw.wdata;
          end else if (fw_start) begin
            op_reg        <= fwg_pkg::OP_ERASE;
            tmr_reg       <= 32'(ERASE_CYC - 1);
            dev_erase_reg <= 1'b0;
          end else if (dbg_any && dbg_ok && i_dbg.wr) begin
            op_reg        <= fwg_pkg::OP_PROG;
            tmr_reg       <= 32'(PROG_CYC - 1);
            prog_addr_reg <= i_dbg.addr[MA_W-1:0];
            prog_data_reg <= i_dbg.wdata;
          end else if (dbg_any && dbg_ok && (i_dbg.page_erase || i_dbg.dev_erase)) begin
            op_reg        <= fwg_pkg::OP_ERASE;
            tmr_reg       <= 32'(ERASE_CYC - 1);
            dev_erase_reg <= i_dbg.dev_erase;
          end
        end
        fwg_pkg::OP_PROG: begin
          if (tmr_zero) begin
            op_reg <= fwg_pkg::OP_DONE;
          end else begin
            tmr_reg <= tmr_reg - 32'h1;
          end
        end
        fwg_pkg::OP_ERASE: begin
          if (tmr_zero && !sweep_act_reg) begin
            op_reg <= fwg_pkg::OP_DONE;
          end else if (!tmr_zero) begin
            tmr_reg <= tmr_reg - 32'h1;
          end
        end
        fwg_pkg::OP_DONE: begin
          op_reg        <= fwg_pkg::OP_IDLE;
          dev_erase_reg <= 1'b0;
        end
        default: begin
          op_reg <= fwg_pkg::OP_IDLE;
        end
      endcase
    end
  end

  // Erase sweep writes one byte a cycle, and the erase operation lasts until the full sweep is done.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sweep_reg     <= '0;
      sweep_end_reg <= '0;
      sweep_act_reg <= 1'b0;
    end else if (i_ce) begin
      if ((op_reg == fwg_pkg::OP_IDLE) && fw_start && psc_reg[fwg_pkg::PSC_EE_BIT]) begin
        sweep_reg     <= i_fw.addr[MA_W-1:0] & ~PAGE_MASK;
        sweep_end_reg <= i_fw.addr[MA_W-1:0] | PAGE_MASK;
        sweep_act_reg <= 1'b1;
      end else if ((op_reg == fwg_pkg::OP_IDLE) && !fw_start && dbg_any && dbg_ok
                   && (i_dbg.page_erase || i_dbg.dev_erase)) begin
        sweep_reg     <= i_dbg.dev_erase ? '0 : (i_dbg.addr[MA_W-1:0] & ~PAGE_MASK);
        sweep_end_reg <= i_dbg.dev_erase ? MA_W'(MEM_BYTES - 1)
                                         : (i_dbg.addr[MA_W-1:0] | PAGE_MASK);
        sweep_act_reg <= 1'b1;
      end else if (sweep_act_reg) begin
        sweep_reg     <= sweep_reg + MA_W'(1);
        sweep_act_reg <= (sweep_reg != sweep_end_reg);
      end
    end
  end

  // Flash array writes; contents are kept across resets like real flash.
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      if (sweep_act_reg) begin
        flash_mem[sweep_reg] <= fwg_pkg::ERASED_BYTE;
      end else if ((op_reg == fwg_pkg::OP_PROG) && tmr_zero) begin
        flash_mem[prog_addr_reg] <= flash_mem[prog_addr_reg] & prog_data_reg;
      end
    end
  end

  // Active lock value is sampled at reset release and set to erased by a device erase, so new lock bytes wait for a reset.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      post_rst_reg <= 1'b1;
      lock_val_reg <= fwg_pkg::LOCK_VAL_RST;
    end else if (i_ce) begin
      post_rst_reg <= 1'b0;
      if (post_rst_reg) begin
        lock_val_reg <= lock_stored;
      end else if ((op_reg == fwg_pkg::OP_DONE) && dev_erase_reg) begin
        lock_val_reg <= fwg_pkg::ERASED_BYTE;
      end
    end
  end

  // The cause must outlive the system reset it triggers, so power-on or the first cycle after reset release clears it.
  always_ff @(posedge i_mclk or posedge i_por) begin
    if (i_por) begin
      ferr_cause_reg <= 1'b0;
    end else if (flash_error_device_reset_req) begin
      ferr_cause_reg <= 1'b1;
    end else if (i_ce && !i_rst && post_rst_reg) begin
      ferr_cause_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rsrc_ferr_reg <= 1'b0;
      o_flash_error_device_reset        <= 1'b0;
    end else if (i_ce) begin
      o_flash_error_device_reset <= flash_error_device_reset_req;
      if (post_rst_reg) begin
        rsrc_ferr_reg <= ferr_cause_reg;
      end
    end
  end

  assign o_core_stall = busy;

  // Read data for firmware and debug port, one cycle after the request.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_fw_rdata    <= 8'h00;
      o_dbg_rdata   <= 8'h00;
      o_dbg_rvalid  <= 1'b0;
      o_dbg_refused <= 1'b0;
    end else if (i_ce) begin
      o_dbg_rvalid  <= dbg_any && dbg_ok && i_dbg.rd;
      o_dbg_refused <= dbg_any && !dbg_ok;
      if (i_fw.rd && !busy && !fw_viol) begin
        o_fw_rdata <= flash_mem[i_fw.addr[MA_W-1:0]];
      end
      if (dbg_any && dbg_ok && i_dbg.rd) begin
        o_dbg_rdata <= flash_mem[i_dbg.addr[MA_W-1:0]];
      end
    end
  end

  // Register read port.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce) begin
      o_reg_rdata <= 8'h00;
      if (i_reg_rd) begin
        case (i_reg_addr)
          fwg_pkg::OFS_PSC: begin
            o_reg_rdata <= {6'h00, psc_reg};
          end
          fwg_pkg::OFS_RSRC: begin
            o_reg_rdata <= 8'(rsrc_ferr_reg) << fwg_pkg::RSRC_FERR_BIT;
          end
          fwg_pkg::OFS_STAT: begin
            o_reg_rdata <= (8'(busy) << fwg_pkg::STAT_BUSY_BIT)
                         | (8'(key_reg == fwg_pkg::KEY_OPEN) << fwg_pkg::STAT_OPEN_BIT)
                         | (8'(key_reg == fwg_pkg::KEY_DEAD) << fwg_pkg::STAT_DEAD_BIT)
                         | (8'(any_locked) << fwg_pkg::STAT_ANYL_BIT);
          end
          fwg_pkg::OFS_LOCK: begin
            o_reg_rdata <= lock_val_reg;
          end
          default: begin
            o_reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end
endmodule // fwg_flash_guard
`default_nettype wire

// *** dv/fwg_flash_guard_properties.sv ***
// Concurrent checks on the ports of the flash write and erase guard.
`timescale 1ns/1ps
`default_nettype none
module fwg_guard_props #(
  parameter int NUM_PAGES = 4,
  parameter int PROG_CYC  = 4
) (
  // Clock, reset, enable and requests
  input wire logic                           i_mclk,
  input wire logic                           i_rst,
  input wire logic                           i_ce,
  input wire logic [fwg_pkg::REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0]                     i_reg_wdata,
  input wire logic                           i_reg_wr,
  input wire fwg_pkg::fwg_fw_req_s           i_fw,
  input wire fwg_pkg::fwg_dbg_req_s          i_dbg,
  input wire logic                           i_supmon_en,
  input wire logic                           i_supmon_rst_en,
  // Answers of the guard
  input wire logic                           o_xdm_to_flash,
  input wire logic                           o_core_stall,
  input wire logic                           o_dbg_rvalid,
  input wire logic                           o_dbg_refused,
  input wire logic                           o_flash_error_device_reset
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  int   run_cnt;
  logic dbg_any;
  assign dbg_any = i_dbg.rd | i_dbg.wr | i_dbg.page_erase | i_dbg.dev_erase;
  // A stall may run far beyond any repetition bound, so its length is counted here.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      run_cnt <= 0;
    end else if (o_core_stall) begin
      run_cnt <= run_cnt + 1;
    end else begin
      run_cnt <= 0;
    end
  end
  property p_stall_len;
    $fell(o_core_stall) |-> run_cnt == PROG_CYC + 1 || run_cnt >= 513;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_stall_cause;
    $rose(o_core_stall) |-> $past(i_fw.wr || i_dbg.wr || i_dbg.page_erase || i_dbg.dev_erase);
  endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without a write");
  property p_supmon;
    i_ce && !$past(i_rst) && i_fw.wr && o_xdm_to_flash && !o_core_stall
      && !(i_supmon_en && i_supmon_rst_en) |=> o_flash_error_device_reset;
  endproperty
  a_supmon: assert property (p_supmon) else $error("no reset on bad supply");
  property p_reserved_fw;
    i_ce && !$past(i_rst) && i_fw.rd && !o_core_stall
      && i_fw.addr[15:9] == 7'(NUM_PAGES - 1) |=> o_flash_error_device_reset;
  endproperty
  a_reserved_fw: assert property (p_reserved_fw) else $error("reserved read not reset");
  property p_reserved_dbg;
    i_ce && !$past(i_rst) && i_dbg.rd && i_dbg.addr[15:9] == 7'(NUM_PAGES - 1) |=> o_dbg_refused;
  endproperty
  a_reserved_dbg: assert property (p_reserved_dbg) else $error("reserved debug read served");
  property p_dbg_answer;
    i_ce && !$past(i_rst) && i_dbg.rd |=> o_dbg_rvalid != o_dbg_refused;
  endproperty
  a_dbg_answer: assert property (p_dbg_answer) else $error("debug read answer wrong");
  property p_dbg_quiet;
    i_ce && dbg_any && !i_fw.rd && !i_fw.wr |=> !o_flash_error_device_reset;
  endproperty
  a_dbg_quiet: assert property (p_dbg_quiet) else $error("debug request reset device");
  property p_xdm_follow;
    i_ce && !$past(i_rst) && i_reg_wr && i_reg_addr == fwg_pkg::OFS_PSC
      |=> o_xdm_to_flash == $past(i_reg_wdata[fwg_pkg::PSC_WE_BIT]);
  endproperty
  a_xdm_follow: assert property (p_xdm_follow) else $error("write enable not applied");
  c_flash_error_device_reset: cover property (o_flash_error_device_reset);
  c_long: cover property ($fell(o_core_stall) && run_cnt >= 513);
  c_refused: cover property (o_dbg_refused);
endmodule // fwg_guard_props

bind fwg_flash_guard fwg_guard_props #(.NUM_PAGES(NUM_PAGES), .PROG_CYC(PROG_CYC)) u_props (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_fw(i_fw), .i_dbg(i_dbg),
  .i_supmon_en(i_supmon_en), .i_supmon_rst_en(i_supmon_rst_en),
  .o_xdm_to_flash(o_xdm_to_flash), .o_core_stall(o_core_stall),
  .o_dbg_rvalid(o_dbg_rvalid), .o_dbg_refused(o_dbg_refused), .o_flash_error_device_reset(o_flash_error_device_reset)
);
`default_nettype wire

// *** dv/fwg_far_model.sv ***
// Behavioural model of the core firmware and the debug port facing the guard.
`timescale 1ns/1ps
`default_nettype none
module fwg_far_model (
  // Clock
  input  wire logic                 i_mclk,
  // Requests towards the guard
  output var fwg_pkg::fwg_fw_req_s  o_fw,
  output var fwg_pkg::fwg_dbg_req_s o_dbg
);
  initial begin
    o_fw  = '0;
    o_dbg = '0;
  end
  task automatic fw_op(input logic rd, input logic wr, input logic [15:0] a,
                       input logic [7:0] d, input logic [15:0] pc);
    @(posedge i_mclk);
    o_fw <= '{rd: rd, wr: wr, addr: a, wdata: d, pc: pc};
    @(posedge i_mclk);
    // A released bus shows the inverse of its last address and data so stale data cannot pass.
    o_fw <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d, pc: pc};
  endtask
  task automatic dbg_op(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_dbg <= {k, a, d};
    @(posedge i_mclk);
    o_dbg <= {4'h0, ~a, ~d};
  endtask
endmodule // fwg_far_model
`default_nettype wire

// *** dv/flash_write_erase_guard_tb_top.sv ***
// Self-checking bench for the flash write and erase guard.
`timescale 1ns/1ps
`default_nettype none
module flash_write_erase_guard_tb_top;
  localparam logic [3:0] PSC = fwg_pkg::OFS_PSC;
  localparam logic [3:0] KEY = fwg_pkg::OFS_KEY;
  localparam logic [3:0] STA = fwg_pkg::OFS_STAT;
  localparam logic [3:0] LCK = fwg_pkg::OFS_LOCK;
  localparam logic [7:0] KA  = fwg_pkg::KEY_FIRST;
  localparam logic [7:0] KB  = fwg_pkg::KEY_SECOND;
  logic                  i_mclk = 1'b0;
  logic                  i_rst = 1'b1;
  logic                  i_por = 1'b1;
  logic                  sup_en = 1'b1;
  logic                  sup_rst = 1'b1;
  logic [3:0]            rg_addr = 4'h0;
  logic [7:0]            rg_wdata = 8'h00;
  logic                  rg_wr = 1'b0;
  logic                  rg_rd = 1'b0;
  logic [7:0]            rg_rdata;
  logic [7:0]            fw_rdata;
  logic [7:0]            dbg_rdata;
  logic                  xdm;
  logic                  stall;
  logic                  dbg_refused;
  logic                  dbg_rvalid;
  logic                  flash_error_device_reset;
  fwg_pkg::fwg_fw_req_s  fw_req;
  fwg_pkg::fwg_dbg_req_s dbg_req;
  int                    miscompares = 0;
  int                    samples_checked = 0;
  always #20 i_mclk = ~i_mclk;
  fwg_far_model u_far (.i_mclk(i_mclk), .o_fw(fw_req), .o_dbg(dbg_req));
  // Short program and erase times keep the run brief; erase still sweeps a page.
  fwg_flash_guard #(.NUM_PAGES(4), .PROG_CYC(4), .ERASE_CYC(8)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por), .i_ce(1'b1),
    .i_reg_addr(rg_addr), .i_reg_wdata(rg_wdata), .i_reg_wr(rg_wr), .i_reg_rd(rg_rd),
    .o_reg_rdata(rg_rdata), .i_fw(fw_req), .o_fw_rdata(fw_rdata), .o_xdm_to_flash(xdm),
    .o_core_stall(stall), .i_supmon_en(sup_en), .i_supmon_rst_en(sup_rst), .i_dbg(dbg_req),
    .o_dbg_rdata(dbg_rdata), .o_dbg_rvalid(dbg_rvalid), .o_dbg_refused(dbg_refused),
    .o_flash_error_device_reset(flash_error_device_reset)
  );
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rst(input logic por);
    i_rst <= 1'b1;
    i_por <= por;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    i_por <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    rg_addr  <= a;
    rg_wdata <= d;
    rg_wr    <= 1'b1;
    @(posedge i_mclk);
    rg_wr <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    rg_addr <= a;
    rg_rd   <= 1'b1;
    @(posedge i_mclk);
    rg_rd <= 1'b0;
    #1 chk(n, exp, rg_rdata);
  endtask
  // The gap between the two codes shows that their spacing does not matter.
  task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
    wr(KEY, k1);
    repeat (7) @(posedge i_mclk);
    wr(KEY, k2);
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (stall === 1'b1 && n < 5000) begin
      @(posedge i_mclk);
      #1 n++;
    end
    if (n == 5000) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic fw(input logic w, input logic [15:0] a, input logic [7:0] d,
                    input logic [15:0] pc, input logic ef, input logic es);
    u_far.fw_op(!w, w, a, d, pc);
    #1 chk("flash_error_device_reset", {7'h0, ef}, {7'h0, flash_error_device_reset});
    chk("stall", {7'h0, es}, {7'h0, stall});
    idle();
  endtask
  task automatic dbg(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d,
                     input logic rf);
    u_far.dbg_op(k, a, d);
    #1 chk("refused", {7'h0, rf}, {7'h0, dbg_refused});
    chk("rvalid", {7'h0, k[3] & !rf}, {7'h0, dbg_rvalid});
    chk("dbg flash_error_device_reset", 8'h00, {7'h0, flash_error_device_reset});
    idle();
  endtask
  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end
  initial begin
    rst(1'b1);
    rd("psc", PSC, 8'h00);
    rd("unmapped", 4'h7, 8'h00);
    dbg(4'h1, 16'h0000, 8'h00, 1'b0);
    rd("lock", LCK, 8'hFF);
    fw(0, 16'h0010, 8'h00, 16'h0000, 0, 0);
    chk("fw rdata", 8'hFF, fw_rdata);
    dbg(4'h8, 16'h05FF, 8'h00, 1'b0);
    chk("dbg rdata", 8'hFF, dbg_rdata);
    wr(PSC, 8'h01);
    #1 chk("to flash", 8'h01, {7'h0, xdm});
    keys(KA, KB);
    rd("key open", STA, 8'h02);
    fw(1, 16'h0010, 8'h5A, 16'h0200, 0, 1);
    rd("relocked", STA, 8'h00);
    rd("psc kept", PSC, 8'h01);
    keys(KA, KB);
    fw(1, 16'h0010, 8'hF0, 16'h0200, 0, 1);
    fw(0, 16'h0010, 8'h00, 16'h0200, 0, 0);
    chk("cleared bits", 8'h50, fw_rdata);
    wr(PSC, 8'h03);
    keys(KA, KB);
    fw(1, 16'h01FE, 8'h00, 16'h0200, 0, 1);
    fw(0, 16'h0010, 8'h00, 16'h0200, 0, 0);
    chk("erased", 8'hFF, fw_rdata);
    wr(PSC, 8'h01);
    fw(1, 16'h0020, 8'h00, 16'h0200, 0, 0);
    keys(KA, KB);
    rd("dead", STA, 8'h04);
    fw(1, 16'h0020, 8'h00, 16'h0200, 0, 0);
    rst(1'b0);
    keys(KB, KA);
    rd("bad order", STA, 8'h04);
    rst(1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(PSC, 8'h01);
      keys(KA, KB);
      {sup_en, sup_rst} <= (i == 0) ? 2'b01 : 2'b10;
      fw(1, 16'h0020, 8'h00, 16'h0200, 1, 0);
      {sup_en, sup_rst} <= 2'b11;
      rst(1'b0);
      rd("error flag", fwg_pkg::OFS_RSRC, 8'h40);
    end
    fw(0, 16'h0600, 8'h00, 16'h0000, 1, 0);
    dbg(4'h8, 16'h0600, 8'h00, 1'b1);
    dbg(4'h4, 16'h0700, 8'h12, 1'b1);
    rst(1'b0);
    wr(PSC, 8'h03);
    keys(KA, KB);
    fw(1, 16'h0500, 8'h00, 16'h0000, 1, 0);
    rst(1'b0);
    dbg(4'h4, 16'h05FF, 8'hFE, 1'b0);
    rd("lock later", LCK, 8'hFF);
    rst(1'b0);
    rd("lock now", LCK, 8'hFE);
    dbg(4'h8, 16'h0010, 8'h00, 1'b1);
    dbg(4'h8, 16'h05FF, 8'h00, 1'b1);
    fw(0, 16'h0010, 8'h00, 16'h0000, 0, 0);
    chk("locked code", 8'hFF, fw_rdata);
    fw(0, 16'h05FF, 8'h00, 16'h0200, 1, 0);
    rst(1'b0);
    dbg(4'h4, 16'h05FF, 8'hFC, 1'b1);
    dbg(4'h2, 16'h0400, 8'h00, 1'b1);
    dbg(4'h1, 16'h0000, 8'h00, 1'b0);
    rd("unlocked", LCK, 8'hFF);
    complete_run();
  end
endmodule // flash_write_erase_guard_tb_top
`default_nettype wire
